// file: src/srwb_pkg.sv
// Package: register map, field layout, power modes and states of the RAM bank 0 write buffer block
package srwb_pkg;
    // Register byte addresses
    localparam logic [11:0] OFF_BUF_STATUS = 12'h000;
    localparam logic [11:0] OFF_PWR_CTRL = 12'h004;
    localparam logic [11:0] OFF_INTR_FLAGS = 12'h008;
    localparam logic [11:0] OFF_INTR_MASK = 12'h00c;
    localparam logic [11:0] OFF_SYS_CTRL = 12'h010;

    // Array power state encodings
    localparam logic [1:0] PM_OFF = 2'h0;
    localparam logic [1:0] PM_RSVD = 2'h1;
    localparam logic [1:0] PM_RETAINED = 2'h2;
    localparam logic [1:0] PM_ENABLE = 2'h3;

    // Interrupt flag positions in system_interrupt_flags
    localparam int IRQ_W = 3;
    localparam int IRQ_DROP = 0;
    localparam int IRQ_RECOV = 1;
    localparam int IRQ_BROWN = 2;
    localparam int LVL_SHIFT = 8;

    // System control bits, write-only actions
    localparam int CTL_SOFT_RST = 0;
    localparam int CTL_DEEPSLEEP = 1;
    localparam int CTL_HIBERNATE = 2;

    // Synchroniser lanes
    localparam int NSYNC = 5;
    localparam int SY_DROP = 0;
    localparam int SY_RECOV = 1;
    localparam int SY_BROWN = 2;
    localparam int SY_WAKE = 3;
    localparam int SY_HIBWAKE = 4;

    localparam logic [3:0] APB_STRB_ALL = 4'hf;
    localparam int BYTE_W = 8;

    typedef enum logic [1:0] {ST_IDLE, ST_MERGE, ST_COMMIT} srwb_state_t;
    typedef enum logic [1:0] {SYS_ACTIVE, SYS_DEEPSLEEP, SYS_HIBERNATE} srwb_sys_t;
endpackage

// file: src/srwb_ctrl.sv
// RAM bank 0 controller: merging write buffer with ECC, power state, supply detector interrupts
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module srwb_ctrl #(
    parameter int WORD_BYTES = 4,
    parameter int DEPTH = 16,
    parameter int ECC_W = 7
) (
    input wire logic REF_CLK, // System clock, 20 MHz
    input wire logic ARST_N, // Asynchronous reset, active low
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction, high for write
    input wire logic [11:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    input wire logic [3:0] PSTRB, // APB write byte strobes
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error, unmapped address
    input wire logic WR_VALID, // Memory write request
    output logic WR_READY, // Write buffer can take a request
    input wire logic [$clog2(DEPTH)-1:0] WR_ADDR, // Word index
    input wire logic [WORD_BYTES*8-1:0] WR_DATA, // Write data
    input wire logic [WORD_BYTES-1:0] WR_STRB, // Byte enables
    input wire logic RD_REQ, // Memory read request, held until RD_VALID
    input wire logic [$clog2(DEPTH)-1:0] RD_ADDR, // Read word index
    output logic RD_VALID, // Read answer pulse
    output logic [WORD_BYTES*8-1:0] RD_DATA, // Read data
    output logic RD_ERR, // ECC mismatch or lost word
    input wire logic SUPPLY_DROP_DET, // Drop detector, high above threshold
    input wire logic SUPPLY_RECOVERY_DET, // Recovery detector, high above threshold
    input wire logic BROWNOUT_RST, // Brownout reset cause level
    input wire logic WAKE_IRQ, // DeepSleep wakeup interrupt
    input wire logic HIB_WAKE_RST, // Hibernate wakeup reset
    output logic IRQ, // Detector interrupt, level
    output logic CPU_HALT // Execution halted in a low-power state
);
    localparam int WORD_W = WORD_BYTES * srwb_pkg::BYTE_W;
    localparam int AW = $clog2(DEPTH);
    // Detector lanes restart at their idle levels so reset release is never taken as an edge
    localparam int SYNC_IDLE_I = (1 << srwb_pkg::SY_DROP) | (1 << srwb_pkg::SY_RECOV);
    localparam logic [srwb_pkg::NSYNC-1:0] SYNC_IDLE = SYNC_IDLE_I[srwb_pkg::NSYNC-1:0];

    typedef struct packed {
        srwb_pkg::srwb_state_t state;
        srwb_pkg::srwb_sys_t sys;
        logic pend;
        logic [AW-1:0] baddr;
        logic [WORD_W-1:0] bdata;
        logic [WORD_BYTES-1:0] bstrb;
        logic [DEPTH-1:0][WORD_W-1:0] mem;
        logic [DEPTH-1:0][ECC_W-1:0] ecc;
        logic [DEPTH-1:0] vld;
        logic [1:0] pmode;
        logic [srwb_pkg::IRQ_W-1:0] ist;
        logic [srwb_pkg::IRQ_W-1:0] imask;
        logic irq;
        logic [srwb_pkg::NSYNC-1:0] sync1;
        logic [srwb_pkg::NSYNC-1:0] sync2;
        logic [srwb_pkg::NSYNC-1:0] prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic wr_ready;
        logic rd_valid;
        logic [WORD_W-1:0] rd_data;
        logic rd_err;
        logic halt;
    } srwb_regs_t;

    srwb_regs_t s_q;
    srwb_regs_t s_d;
    logic rst_meta_q;
    logic rst_sync_q;

    // Folded parity: each check bit covers every ECC_W-th data bit
    function automatic logic [ECC_W-1:0] ecc_of(input logic [WORD_W-1:0] w);
        logic [ECC_W-1:0] e;
        e = '0;
        for (int i = 0; i < WORD_W; i++)
        begin
            e[i % ECC_W] = e[i % ECC_W] ^ w[i];
        end
        return e;
    endfunction

    // Edge seen on a synchronised lane; rise picks the direction.
    // Both detector flags use it so the two edge tests cannot drift apart.
    function automatic logic lane_edge(input logic was, input logic now, input logic rise);
        return rise ? (!was && now) : (was && !now);
    endfunction

    function automatic logic addr_hit(input logic [11:0] a);
        return (a == srwb_pkg::OFF_BUF_STATUS) || (a == srwb_pkg::OFF_PWR_CTRL)
            || (a == srwb_pkg::OFF_INTR_FLAGS) || (a == srwb_pkg::OFF_INTR_MASK)
            || (a == srwb_pkg::OFF_SYS_CTRL);
    endfunction

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    always_comb
    begin
        logic setup;
        logic wr_acc;
        logic soft_rst;
        logic engine_on;
        logic [WORD_W-1:0] old_w;
        logic [31:0] rmux;
        s_d = s_q;
        setup = PSEL && !PENABLE;
        wr_acc = PSEL && PENABLE && PWRITE && s_q.pready;
        soft_rst = 1'b0;
        engine_on = (s_q.pmode == srwb_pkg::PM_ENABLE) && (s_q.sys == srwb_pkg::SYS_ACTIVE);
        old_w = s_q.vld[s_q.baddr] ? s_q.mem[s_q.baddr] : '0;
        rmux = '0;

        s_d.sync1 = {HIB_WAKE_RST, WAKE_IRQ, BROWNOUT_RST, SUPPLY_RECOVERY_DET, SUPPLY_DROP_DET};
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        s_d.rd_valid = 1'b0;

        // APB register access; clears are applied before hardware sets so a set wins
        if (wr_acc)
        begin
            unique case (PADDR)
                srwb_pkg::OFF_PWR_CTRL:
                begin
                    // Sub-word writes and the reserved code leave the field unchanged
                    if (PSTRB == srwb_pkg::APB_STRB_ALL && PWDATA[1:0] != srwb_pkg::PM_RSVD)
                    begin
                        s_d.pmode = PWDATA[1:0];
                    end
                end
                srwb_pkg::OFF_INTR_FLAGS:
                begin
                    s_d.ist = s_q.ist & ~PWDATA[srwb_pkg::IRQ_W-1:0];
                end
                srwb_pkg::OFF_INTR_MASK:
                begin
                    s_d.imask = PWDATA[srwb_pkg::IRQ_W-1:0];
                end
                srwb_pkg::OFF_SYS_CTRL:
                begin
                    soft_rst = PWDATA[srwb_pkg::CTL_SOFT_RST];
                    if (PWDATA[srwb_pkg::CTL_HIBERNATE])
                    begin
                        s_d.sys = srwb_pkg::SYS_HIBERNATE;
                    end
                    else if (PWDATA[srwb_pkg::CTL_DEEPSLEEP])
                    begin
                        s_d.sys = srwb_pkg::SYS_DEEPSLEEP;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Detector and brownout events
        if (lane_edge(s_q.prev[srwb_pkg::SY_DROP], s_q.sync2[srwb_pkg::SY_DROP], 1'b0))
        begin
            s_d.ist[srwb_pkg::IRQ_DROP] = 1'b1;
        end
        if (lane_edge(s_q.prev[srwb_pkg::SY_RECOV], s_q.sync2[srwb_pkg::SY_RECOV], 1'b1))
        begin
            s_d.ist[srwb_pkg::IRQ_RECOV] = 1'b1;
        end
        if (s_q.sync2[srwb_pkg::SY_BROWN])
        begin
            s_d.ist[srwb_pkg::IRQ_BROWN] = 1'b1;
        end

        // Write buffer: take, merge with stored bytes, then commit word and check bits.
        // The engine only runs with the array enabled, so a pending word stays stuck
        // in retained state and is lost by a later reset.
        unique case (s_q.state)
            srwb_pkg::ST_IDLE:
            begin
                if (WR_VALID && s_q.wr_ready)
                begin
                    s_d.pend = 1'b1;
                    s_d.baddr = WR_ADDR;
                    s_d.bdata = WR_DATA;
                    s_d.bstrb = WR_STRB;
                    s_d.state = srwb_pkg::ST_MERGE;
                end
            end
            srwb_pkg::ST_MERGE:
            begin
                if (engine_on)
                begin
                    for (int b = 0; b < WORD_BYTES; b++)
                    begin
                        if (!s_q.bstrb[b])
                        begin
                            s_d.bdata[b*srwb_pkg::BYTE_W +: srwb_pkg::BYTE_W] =
                                old_w[b*srwb_pkg::BYTE_W +: srwb_pkg::BYTE_W];
                        end
                    end
                    s_d.bstrb = '1;
                    s_d.state = srwb_pkg::ST_COMMIT;
                end
            end
            srwb_pkg::ST_COMMIT:
            begin
                if (engine_on)
                begin
                    s_d.mem[s_q.baddr] = s_q.bdata;
                    s_d.ecc[s_q.baddr] = ecc_of(s_q.bdata);
                    s_d.vld[s_q.baddr] = 1'b1;
                    s_d.pend = 1'b0;
                    s_d.state = srwb_pkg::ST_IDLE;
                end
            end
        endcase

        // Reads wait for a drained buffer so they never see stale data
        if (RD_REQ && !s_q.rd_valid && !s_q.pend && engine_on)
        begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data = s_q.vld[RD_ADDR] ? s_q.mem[RD_ADDR] : '0;
            s_d.rd_err = !s_q.vld[RD_ADDR] || (ecc_of(s_q.mem[RD_ADDR]) != s_q.ecc[RD_ADDR]);
        end

        if (s_d.pmode == srwb_pkg::PM_OFF)
        begin
            s_d.vld = '0;
        end

        // Low-power states
        if (s_q.sys == srwb_pkg::SYS_DEEPSLEEP && s_q.sync2[srwb_pkg::SY_WAKE])
        begin
            s_d.sys = srwb_pkg::SYS_ACTIVE;
        end
        if (s_q.sys == srwb_pkg::SYS_HIBERNATE)
        begin
            s_d.vld = '0;
            s_d.sys = srwb_pkg::SYS_HIBERNATE;
            soft_rst = s_q.sync2[srwb_pkg::SY_HIBWAKE];
        end

        // Software and Hibernate wakeup reset: power state, mask-free brownout cause survive
        if (soft_rst)
        begin
            s_d.state = srwb_pkg::ST_IDLE;
            s_d.pend = 1'b0;
            s_d.sys = srwb_pkg::SYS_ACTIVE;
            s_d.ist = s_d.ist & (srwb_pkg::IRQ_W'(1) << srwb_pkg::IRQ_BROWN);
            s_d.imask = '0;
            s_d.rd_valid = 1'b0;
            if (s_q.pmode != srwb_pkg::PM_RETAINED)
            begin
                s_d.vld = '0;
            end
            s_d.pmode = s_q.pmode;
        end

        // APB answer is prepared in the setup phase so PREADY and PRDATA come from flops
        unique case (PADDR)
            srwb_pkg::OFF_BUF_STATUS: rmux = 32'(!s_q.pend);
            srwb_pkg::OFF_PWR_CTRL: rmux = 32'(s_q.pmode);
            srwb_pkg::OFF_INTR_FLAGS: rmux = 32'(s_q.ist)
                | (32'(s_q.sync2[srwb_pkg::SY_RECOV:srwb_pkg::SY_DROP]) << srwb_pkg::LVL_SHIFT);
            srwb_pkg::OFF_INTR_MASK: rmux = 32'(s_q.imask);
            default: rmux = '0;
        endcase
        s_d.pready = setup;
        s_d.pslverr = setup && !addr_hit(PADDR);
        if (setup)
        begin
            s_d.prdata = PWRITE ? '0 : rmux;
        end

        s_d.halt = (s_d.sys != srwb_pkg::SYS_ACTIVE);
        s_d.wr_ready = !s_d.pend && (s_d.pmode == srwb_pkg::PM_ENABLE)
            && (s_d.sys == srwb_pkg::SYS_ACTIVE);
        s_d.irq = |(s_d.ist & s_d.imask);
    end

    // Reset clears the buffer mid-write; nothing waits for an access to finish
    always_ff @(posedge REF_CLK or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            s_q <= '0;
            s_q.pmode <= srwb_pkg::PM_ENABLE;
            s_q.sync1 <= SYNC_IDLE;
            s_q.sync2 <= SYNC_IDLE;
            s_q.prev <= SYNC_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign PRDATA = s_q.prdata;
    assign PREADY = s_q.pready;
    assign PSLVERR = s_q.pslverr;
    assign WR_READY = s_q.wr_ready;
    assign RD_VALID = s_q.rd_valid;
    assign RD_DATA = s_q.rd_data;
    assign RD_ERR = s_q.rd_err;
    assign IRQ = s_q.irq;
    assign CPU_HALT = s_q.halt;
endmodule // srwb_ctrl

// file: tb/srwb_ctrl_chk.sv
// Checker: port-level timing properties of the RAM bank 0 controller
`timescale 1ns/100ps
module srwb_chk #(
    parameter int WORD_BYTES = 4
) (
    input wire logic REF_CLK, // Clock
    input wire logic ARST_N, // Reset
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PREADY, // APB ready
    input wire logic PSLVERR, // APB error
    input wire logic WR_VALID, // Write request
    input wire logic WR_READY, // Write ready
    input wire logic RD_REQ, // Read request
    input wire logic RD_VALID, // Read answer
    input wire logic [WORD_BYTES*8-1:0] RD_DATA, // Read data
    input wire logic RD_ERR // Read error
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    a_apb_zero_wait: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("ready missing after setup");
    a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_wr_commit_time: assert property (WR_VALID && WR_READY |=> !WR_READY ##1 !WR_READY ##1 WR_READY)
        else $error("write commit timing wrong");
    a_rd_one_pulse: assert property (RD_VALID |=> !RD_VALID)
        else $error("read answer too long");
    a_rd_has_cause: assert property ($rose(RD_VALID) |-> $past(RD_REQ))
        else $error("read answer without request");
    a_rd_data_hold: assert property (!RD_VALID |-> $stable(RD_DATA))
        else $error("read data moved");
    a_rd_err_hold: assert property ($changed(RD_ERR) |-> RD_VALID)
        else $error("read error moved");
endmodule // srwb_chk

bind srwb_ctrl srwb_chk #(.WORD_BYTES(WORD_BYTES)) u_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .WR_VALID(WR_VALID),
    .WR_READY(WR_READY), .RD_REQ(RD_REQ), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
    .RD_ERR(RD_ERR));

// file: tb/srwb_cpu_mdl.sv
// Partner model: CPU-side master of the memory write and read ports
`timescale 1ns/100ps
module srwb_cpu_mdl (
    input wire logic clk, // System clock
    input wire logic wr_ready, // Buffer can take a write
    input wire logic rd_valid, // Read answer
    input wire logic [31:0] rd_data, // Read data
    input wire logic rd_err, // Read error
    output logic wr_valid = 1'b0, // Write request
    output logic [3:0] wr_addr = 4'h0, // Write word index
    output logic [31:0] wr_data = 32'h0, // Write data
    output logic [3:0] wr_strb = 4'h0, // Byte enables
    output logic rd_req = 1'b0, // Read request
    output logic [3:0] rd_addr = 4'h0 // Read word index
);
    // Released write data and read address flip so a stale value can never pass for a fresh one
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        wr_addr <= a;
        wr_data <= d;
        wr_strb <= s;
        wr_valid <= 1'b1;
        @(posedge clk);
        while (wr_ready !== 1'b1) @(posedge clk);
        wr_valid <= 1'b0;
        wr_data <= ~d;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic e);
        rd_addr <= a;
        rd_req <= 1'b1;
        @(posedge clk);
        while (rd_valid !== 1'b1) @(posedge clk);
        d = rd_data;
        e = rd_err;
        rd_req <= 1'b0;
        rd_addr <= ~a;
        @(posedge clk);
    endtask
endmodule // srwb_cpu_mdl

// file: tb/srwb_ctrl_test.sv
// Testbench: registers, memory ports, detectors and low power against a behavioural model
`timescale 1ns/100ps
module srwb_ctrl_test;
    localparam logic [11:0] A_ST = srwb_pkg::OFF_BUF_STATUS;
    localparam logic [11:0] A_PW = srwb_pkg::OFF_PWR_CTRL;
    localparam logic [11:0] A_FL = srwb_pkg::OFF_INTR_FLAGS;
    localparam logic [11:0] A_MK = srwb_pkg::OFF_INTR_MASK;
    localparam logic [11:0] A_SY = srwb_pkg::OFF_SYS_CTRL;
    logic REF_CLK = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h0;
    logic [31:0] PWDATA = 32'h0, PRDATA, RD_DATA, WR_DATA, rdat;
    logic [3:0] PSTRB = 4'hf, WR_STRB, WR_ADDR, RD_ADDR, ra;
    logic PREADY, PSLVERR, WR_VALID, WR_READY, RD_REQ, RD_VALID, RD_ERR, IRQ, CPU_HALT, rerr;
    logic SUPPLY_DROP_DET = 1'b1, SUPPLY_RECOVERY_DET = 1'b1, BROWNOUT_RST = 1'b0;
    logic WAKE_IRQ = 1'b0, HIB_WAKE_RST = 1'b0;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    logic [31:0] mem [16];
    bit vld [16];
    srwb_ctrl uut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
        .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .WR_STRB(WR_STRB), .RD_REQ(RD_REQ),
        .RD_ADDR(RD_ADDR), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .RD_ERR(RD_ERR),
        .SUPPLY_DROP_DET(SUPPLY_DROP_DET), .SUPPLY_RECOVERY_DET(SUPPLY_RECOVERY_DET),
        .BROWNOUT_RST(BROWNOUT_RST), .WAKE_IRQ(WAKE_IRQ), .HIB_WAKE_RST(HIB_WAKE_RST),
        .IRQ(IRQ), .CPU_HALT(CPU_HALT));
    srwb_cpu_mdl mdl (.clk(REF_CLK), .wr_ready(WR_READY), .rd_valid(RD_VALID),
        .rd_data(RD_DATA), .rd_err(RD_ERR), .wr_valid(WR_VALID), .wr_addr(WR_ADDR),
        .wr_data(WR_DATA), .wr_strb(WR_STRB), .rd_req(RD_REQ), .rd_addr(RD_ADDR));
    always #25 REF_CLK = ~REF_CLK;
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // A healthy run needs under a thousand cycles
    always @(posedge REF_CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x)
        begin
            $display("MISMATCH %s expected %h seen %h", n, x, s);
            bad_count++;
        end
    endtask
    task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        PSTRB <= s;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK);
        while (PREADY !== 1'b1) @(posedge REF_CLK);
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        PWDATA <= ~d;
        @(posedge REF_CLK);
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        ap(1'b1, a, d, 4'hf);
    endtask
    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] x);
        ap(1'b0, a, 32'h0, 4'hf);
        chk(n, rdat, x);
    endtask
    task automatic mwr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        mdl.wr(a, d, s);
        if (!vld[a])
            mem[a] = 32'h0;
        for (int b = 0; b < 4; b++)
            if (s[b]) mem[a][8*b+:8] = d[8*b+:8];
        vld[a] = 1'b1;
    endtask
    task automatic mrd(input logic [3:0] a);
        logic [31:0] d;
        logic e;
        mdl.rd(a, d, e);
        chk("rd_data", d, vld[a] ? mem[a] : 32'h0);
        chk("rd_err", {31'h0, e}, {31'h0, !vld[a]});
    endtask
    task automatic wipe;
        foreach (vld[i]) vld[i] = 1'b0;
    endtask
    // Drain the buffer, then park the array in retention
    task automatic retain;
        do ap(1'b0, A_ST, 32'h0, 4'hf); while (rdat[0] !== 1'b1);
        wreg(A_PW, 32'h2);
    endtask
    initial
    begin
        void'($urandom(51));
        repeat (16) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        rchk("status", A_ST, 32'h1);
        rchk("power", A_PW, 32'h3);
        ap(1'b0, 12'h020, 32'h0, 4'hf);
        chk("slverr", {31'h0, rerr}, 32'h1);
        for (int i = 0; i < 8; i++)
        begin
            ra = 4'($urandom_range(0, 3));
            mwr(ra, $urandom, 4'($urandom_range(1, 15)));
            mrd(ra);
        end
        fork
            mwr(4'h9, $urandom, 4'hf);
            begin
                @(posedge REF_CLK);
                rchk("pending", A_ST, 32'h0);
            end
        join
        wreg(A_PW, 32'h1);
        rchk("power", A_PW, 32'h3);
        ap(1'b1, A_PW, 32'h2, 4'h3);
        rchk("power", A_PW, 32'h3);
        retain();
        wreg(A_SY, 32'h1);
        rchk("power", A_PW, 32'h2);
        wreg(A_PW, 32'h3);
        mrd(4'h9);
        wreg(A_PW, 32'h0);
        wreg(A_PW, 32'h3);
        wipe();
        mrd(4'h9);
        wreg(A_MK, 32'h3);
        SUPPLY_DROP_DET <= 1'b0;
        repeat (5) @(posedge REF_CLK);
        chk("irq", {31'h0, IRQ}, 32'h1);
        rchk("flags", A_FL, 32'h201);
        wreg(A_FL, 32'h1);
        repeat (2) @(posedge REF_CLK);
        chk("irq", {31'h0, IRQ}, 32'h0);
        SUPPLY_DROP_DET <= 1'b1;
        SUPPLY_RECOVERY_DET <= 1'b0;
        repeat (5) @(posedge REF_CLK);
        SUPPLY_RECOVERY_DET <= 1'b1;
        repeat (5) @(posedge REF_CLK);
        rchk("flags", A_FL, 32'h302);
        chk("irq", {31'h0, IRQ}, 32'h1);
        wreg(A_MK, 32'h0);
        repeat (2) @(posedge REF_CLK);
        chk("irq", {31'h0, IRQ}, 32'h0);
        BROWNOUT_RST <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        BROWNOUT_RST <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        wreg(A_SY, 32'h1);
        wipe();
        rchk("flags", A_FL, 32'h304);
        wreg(A_FL, 32'h7);
        rchk("flags", A_FL, 32'h300);
        mwr(4'h5, $urandom, 4'hf);
        retain();
        wreg(A_SY, 32'h2);
        repeat (2) @(posedge REF_CLK);
        chk("halt", {31'h0, CPU_HALT}, 32'h1);
        WAKE_IRQ <= 1'b1;
        repeat (5) @(posedge REF_CLK);
        chk("halt", {31'h0, CPU_HALT}, 32'h0);
        WAKE_IRQ <= 1'b0;
        wreg(A_PW, 32'h3);
        mrd(4'h5);
        wreg(A_SY, 32'h4);
        WAKE_IRQ <= 1'b1;
        repeat (5) @(posedge REF_CLK);
        chk("halt", {31'h0, CPU_HALT}, 32'h1);
        WAKE_IRQ <= 1'b0;
        HIB_WAKE_RST <= 1'b1;
        repeat (5) @(posedge REF_CLK);
        chk("halt", {31'h0, CPU_HALT}, 32'h0);
        HIB_WAKE_RST <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        wipe();
        mrd(4'h5);
        mwr(4'h7, $urandom, 4'hf);
        ARST_N <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        wipe();
        mrd(4'h7);
        rchk("power", A_PW, 32'h3);
        summarize();
    end
endmodule // srwb_ctrl_test
